/* File: logic/uifd_desc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uifd_regs.svh"
module uifd_desc
  import uifd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic req,
  input var uifd_sel_t req_sel,
  input var uifd_speed_t speed,
  input var uifd_image_t image,
  input wire logic byte_ready,
  output var uifd_byte_t byte_out,
  output logic busy
);
  uifd_state_t s_r;
  uifd_state_t s_nxt;
  logic [7:0] cur_byte;
  logic [7:0] ivl;
  logic [15:0] mps;
  logic [4:0] len;
  logic [7:0] ep_addr;
  logic is_int;

  // Fixed interface fields never come from the image, so a bad image cannot break them
  always_comb
  begin
    is_int = (s_r.sel == UIFD_SEL_INT);
    unique case (speed)
      UIFD_HS: mps = `UIFD_MPS_HS;
      UIFD_SS: mps = `UIFD_MPS_SS;
      default: mps = `UIFD_MPS_FS;
    endcase
    if (is_int)
      mps = `UIFD_MPS_INT;
    if (speed == UIFD_SS)
      ivl = `UIFD_IVL_SS_DEF;
    else if (!image.valid)
      ivl = (speed == UIFD_HS) ? `UIFD_IVL_HS_DEF : `UIFD_IVL_FS_DEF;
    else
      ivl = (speed == UIFD_HS) ? image.ivl_hs : image.ivl_fs;
    unique case (s_r.sel)
      UIFD_SEL_BIN: ep_addr = `UIFD_EP_BIN_ADDR;
      UIFD_SEL_BOUT: ep_addr = `UIFD_EP_BOUT_ADDR;
      default: ep_addr = `UIFD_EP_INT_ADDR;
    endcase
    len = (s_r.sel == UIFD_SEL_IF) ? `UIFD_IF_BYTES : `UIFD_EP_BYTES;
    cur_byte = 8'h00;
    if (s_r.sel == UIFD_SEL_IF)
    begin
      unique case (s_r.idx)
        5'h00: cur_byte = `UIFD_IF_LEN;
        5'h01: cur_byte = `UIFD_IF_TYPE;
        5'h02: cur_byte = `UIFD_IF_NUM;
        5'h03: cur_byte = `UIFD_IF_ALT;
        5'h04: cur_byte = `UIFD_IF_NEP;
        5'h05: cur_byte = image.valid ? image.if_class : `UIFD_IF_CLASS_DEF;
        5'h06: cur_byte = image.valid ? image.if_sub : `UIFD_IF_SUB_DEF;
        5'h07: cur_byte = image.valid ? image.if_proto : `UIFD_IF_PROTO_DEF;
        5'h08: cur_byte = image.valid ? image.if_str : `UIFD_IF_STR_DEF;
        default: cur_byte = 8'h00;
      endcase
    end
    else
    begin
      unique case (s_r.idx)
        5'h00: cur_byte = `UIFD_EP_LEN;
        5'h01: cur_byte = `UIFD_EP_TYPE;
        5'h02: cur_byte = ep_addr;
        5'h03: cur_byte = is_int ? `UIFD_EP_INT_ATTR : `UIFD_EP_BULK_ATTR;
        5'h04: cur_byte = mps[7:0];
        5'h05: cur_byte = mps[15:8];
        5'h06: cur_byte = is_int ? ivl : `UIFD_BULK_IVL;
        default: cur_byte = 8'h00;
      endcase
    end
  end

  // Output byte holds until taken, so a stalled sink loses nothing
  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.st)
      UIFD_IDLE:
      begin
        s_nxt.out = '0;
        if (req)
        begin
          s_nxt.st = UIFD_SEND;
          s_nxt.sel = req_sel;
          s_nxt.idx = 5'h00;
        end
      end
      UIFD_SEND:
      begin
        if (!s_r.out.valid || byte_ready)
        begin
          if (s_r.out.valid && s_r.out.last)
          begin
            s_nxt.st = UIFD_IDLE;
            s_nxt.out = '0;
          end
          else
          begin
            s_nxt.out.valid = 1'b1;
            s_nxt.out.data = cur_byte;
            s_nxt.out.last = (s_r.idx == len - 5'h01);
            s_nxt.idx = s_r.idx + 5'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign byte_out = s_r.out;
  assign busy = s_r.st;

  first_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) && s_r.sel == UIFD_SEL_IF |-> ##1 byte_out.valid && byte_out.data == 8'h09)
    else $error("interface length byte wrong");
  ep_first_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(busy) && s_r.sel != UIFD_SEL_IF |-> ##1 byte_out.data == 8'h07)
    else $error("endpoint length byte wrong");
  hold_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && !byte_ready |=> byte_out.valid && $stable(byte_out.data))
    else $error("byte changed while stalled");
  last_if_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && byte_out.last && s_r.sel == UIFD_SEL_IF |-> s_r.idx == 5'h09)
    else $error("interface descriptor length wrong");
  last_ep_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && byte_out.last && s_r.sel != UIFD_SEL_IF |-> s_r.idx == 5'h07)
    else $error("endpoint descriptor length wrong");
  ss_ivl_a: assert property (@(posedge core_clk) disable iff (rst)
    busy && s_r.sel == UIFD_SEL_INT && s_r.idx == 5'h06 && speed == UIFD_SS
    |-> cur_byte == 8'h06)
    else $error("superspeed interval wrong");
  bulk_mps_a: assert property (@(posedge core_clk) disable iff (rst)
    busy && !is_int && s_r.sel != UIFD_SEL_IF && s_r.idx == 5'h05 && speed == UIFD_HS
    |-> cur_byte == 8'h02)
    else $error("high speed bulk packet size wrong");
  done_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && byte_out.last && byte_ready |=> !busy && !byte_out.valid)
    else $error("no return to idle after last byte");
  if_type_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx == 5'h02
    |-> byte_out.data == 8'h04)
    else $error("interface type byte wrong");
  if_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx inside {5'h03, 5'h04}
    |-> byte_out.data == 8'h00)
    else $error("interface number or alternate wrong");
  if_nep_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx == 5'h05
    |-> byte_out.data == 8'h03)
    else $error("endpoint count wrong");
  if_class_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx == 5'h06 && !image.valid
    |-> byte_out.data == 8'hFF)
    else $error("default class wrong");
  if_over_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx == 5'h06 && image.valid
    |-> byte_out.data == image.if_class)
    else $error("class override not applied");
  if_str_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_IF && s_r.idx == 5'h09
    |-> byte_out.data == (image.valid ? image.if_str : 8'h00))
    else $error("string index wrong");
  ep_type_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel != UIFD_SEL_IF && s_r.idx == 5'h02
    |-> byte_out.data == 8'h05)
    else $error("endpoint type byte wrong");
  bin_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_BIN && s_r.idx == 5'h03
    |-> byte_out.data == 8'h81)
    else $error("bulk in address wrong");
  bout_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_BOUT && s_r.idx == 5'h03
    |-> byte_out.data == 8'h02)
    else $error("bulk out address wrong");
  int_addr_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_INT && s_r.idx == 5'h03
    |-> byte_out.data == 8'h83)
    else $error("interrupt address wrong");
  int_mps_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && s_r.sel == UIFD_SEL_INT && s_r.idx == 5'h05
    |-> byte_out.data == 8'h10)
    else $error("interrupt packet size wrong");
  bulk_attr_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && (s_r.sel == UIFD_SEL_BIN || s_r.sel == UIFD_SEL_BOUT) && s_r.idx == 5'h04
    |-> byte_out.data == 8'h02)
    else $error("bulk attribute wrong");
  bulk_ivl_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && (s_r.sel == UIFD_SEL_BIN || s_r.sel == UIFD_SEL_BOUT) && s_r.idx == 5'h07
    |-> byte_out.data == 8'h00)
    else $error("bulk interval not zero");
  ss_mps_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && !is_int && s_r.sel != UIFD_SEL_IF && s_r.idx == 5'h06 && speed == UIFD_SS
    |-> byte_out.data == 8'h04)
    else $error("superspeed bulk packet size wrong");
  int_ivl_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && is_int && s_r.idx == 5'h07 && image.valid && speed == UIFD_HS
    |-> byte_out.data == image.ivl_hs)
    else $error("high speed image interval wrong");
  fs_ivl_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && is_int && s_r.idx == 5'h07 && !image.valid && speed == UIFD_FS
    |-> byte_out.data == 8'h01)
    else $error("full speed default interval wrong");
  next_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    byte_out.valid && byte_ready && !byte_out.last
    |=> byte_out.valid && s_r.idx == $past(s_r.idx) + 5'h01)
    else $error("bytes not in ascending order");
endmodule
`default_nettype wire

/* File: logic/uifd_regs.svh */
`ifndef UIFD_REGS_SVH
`define UIFD_REGS_SVH
`define UIFD_IF_LEN 8'h09
`define UIFD_IF_TYPE 8'h04
`define UIFD_IF_NUM 8'h00
`define UIFD_IF_ALT 8'h00
`define UIFD_IF_NEP 8'h03
`define UIFD_IF_CLASS_DEF 8'hFF
`define UIFD_IF_SUB_DEF 8'h00
`define UIFD_IF_PROTO_DEF 8'hFF
`define UIFD_IF_STR_DEF 8'h00
`define UIFD_EP_LEN 8'h07
`define UIFD_EP_TYPE 8'h05
`define UIFD_EP_BIN_ADDR 8'h81
`define UIFD_EP_BOUT_ADDR 8'h02
`define UIFD_EP_INT_ADDR 8'h83
`define UIFD_EP_BULK_ATTR 8'h02
`define UIFD_EP_INT_ATTR 8'h03
`define UIFD_MPS_FS 16'h0040
`define UIFD_MPS_HS 16'h0200
`define UIFD_MPS_SS 16'h0400
`define UIFD_MPS_INT 16'h0010
`define UIFD_BULK_IVL 8'h00
`define UIFD_IVL_HS_DEF 8'h04
`define UIFD_IVL_FS_DEF 8'h01
`define UIFD_IVL_SS_DEF 8'h06
`define UIFD_IF_BYTES 5'h09
`define UIFD_EP_BYTES 5'h07
`endif

/* File: logic/uifd_pkg.sv */
`default_nettype none
package uifd_pkg;
  typedef enum logic [1:0] {UIFD_FS = 2'h0, UIFD_HS = 2'h1, UIFD_SS = 2'h2} uifd_speed_t;
  typedef enum logic [1:0] {UIFD_SEL_IF = 2'h0, UIFD_SEL_BIN = 2'h1, UIFD_SEL_BOUT = 2'h2,
    UIFD_SEL_INT = 2'h3} uifd_sel_t;
  typedef enum logic {UIFD_IDLE = 1'b0, UIFD_SEND = 1'b1} uifd_st_t;
  typedef struct packed {
    logic valid;
    logic [7:0] if_class;
    logic [7:0] if_sub;
    logic [7:0] if_proto;
    logic [7:0] if_str;
    logic [7:0] ivl_fs;
    logic [7:0] ivl_hs;
  } uifd_image_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } uifd_byte_t;
  typedef struct packed {
    uifd_st_t st;
    uifd_sel_t sel;
    logic [4:0] idx;
    uifd_byte_t out;
  } uifd_state_t;
endpackage
`default_nettype wire

/* File: sim/uifd_host_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module uifd_host_sink
  import uifd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic slow,
  output logic byte_ready
);
  logic [1:0] cnt_r;
  // Slow host is ready one cycle in three, to stretch each byte's hold
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cnt_r <= 2'h0;
    else
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
  assign byte_ready = !slow || (cnt_r == 2'h2);
endmodule
`default_nettype wire

/* File: sim/usb_iface_endpoint_descriptors_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module usb_iface_endpoint_descriptors_bench;
  import uifd_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  logic slow = 1'b0;
  uifd_sel_t req_sel = UIFD_SEL_IF;
  uifd_speed_t speed = UIFD_FS;
  uifd_image_t image = '0;
  logic byte_ready;
  uifd_byte_t byte_out;
  logic busy;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [7:0] exp_q[$];
  always #12.5 core_clk = ~core_clk;
  uifd_desc dut (.core_clk(core_clk), .rst(rst), .req(req), .req_sel(req_sel),
    .speed(speed), .image(image), .byte_ready(byte_ready), .byte_out(byte_out), .busy(busy));
  uifd_host_sink host (.core_clk(core_clk), .rst(rst), .slow(slow), .byte_ready(byte_ready));
  task automatic complete_run();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Bytes are judged 2 ns after the edge before the one that accepts them
  task automatic fetch(input uifd_sel_t sel);
    int w;
    @(posedge core_clk);
    #2;
    req_sel = sel;
    req = 1'b1;
    @(posedge core_clk);
    #2;
    req = 1'b0;
    `CHK(busy, 1'b1)
    for (int k = 0; k < exp_q.size(); k++)
    begin
      w = 0;
      while (!(byte_out.valid === 1'b1 && byte_ready === 1'b1) && w < 50)
      begin
        @(posedge core_clk);
        #2;
        w++;
      end
      `CHK(byte_out.data, exp_q[k])
      `CHK(byte_out.last, k == exp_q.size() - 1)
      @(posedge core_clk);
      #2;
    end
    `CHK({byte_out.valid, busy}, 2'h0)
  endtask
  // A request while busy must not redirect the descriptor; reset must cut it cleanly
  task automatic t_reset();
    slow = 1'b0;
    exp_q = '{8'h07, 8'h05, 8'h81, 8'h02, 8'h00, 8'h04, 8'h00};
    @(posedge core_clk);
    #2;
    req_sel = UIFD_SEL_BIN;
    req = 1'b1;
    @(posedge core_clk);
    #2;
    req_sel = UIFD_SEL_INT;
    repeat (3) @(posedge core_clk);
    #2;
    `CHK(byte_out.data, 8'h81)
    req = 1'b0;
    rst = 1'b1;
    #1;
    `CHK({byte_out.valid, busy}, 2'h0)
    repeat (2) @(posedge core_clk);
    #2;
    rst = 1'b0;
    fetch(UIFD_SEL_BIN);
  endtask
  task automatic t_iface();
    exp_q = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'hFF, 8'h00, 8'hFF, 8'h00};
    fetch(UIFD_SEL_IF);
    slow = 1'b1;
    image = '{1'b1, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
    exp_q = '{8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'h11, 8'h22, 8'h33, 8'h44};
    fetch(UIFD_SEL_IF);
    slow = 1'b0;
  endtask
  task automatic t_bulk();
    for (int s = 0; s < 3; s++)
    begin
      speed = uifd_speed_t'(s);
      exp_q = '{8'h07, 8'h05, 8'h81, 8'h02, s ? 8'h00 : 8'h40, 8'(s * 2), 8'h00};
      fetch(UIFD_SEL_BIN);
      exp_q[2] = 8'h02;
      fetch(UIFD_SEL_BOUT);
    end
  endtask
  task automatic t_int();
    slow = 1'b1;
    for (int v = 0; v < 2; v++)
      for (int s = 0; s < 3; s++)
      begin
        image.valid = v[0];
        speed = uifd_speed_t'(s);
        exp_q = '{8'h07, 8'h05, 8'h83, 8'h03, 8'h10, 8'h00,
          s == 2 ? 8'h06 : v ? (s ? 8'h66 : 8'h55) : (s ? 8'h04 : 8'h01)};
        fetch(UIFD_SEL_INT);
      end
  endtask
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      complete_run();
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk);
    #2;
    rst = 1'b0;
    t_iface();
    t_bulk();
    t_int();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
